// >>> src/ptg_pkg.sv
// Purpose: Shared constants for the pin test and general-purpose pin logic
// Assumes: One 125 MHz clock, active-low asynchronous reset
// Notes:   Offsets are those of the config and operating register spaces
package ptg_pkg;

   // Register offsets
   localparam logic [7:0] PTG_PIN_STATE_OFF = 8'h07;
   localparam logic [7:0] PTG_PIN_CTRL_OFF  = 8'h35;

   // Pin control register fields
   localparam int PTG_CTL_GP0_DATA = 0;
   localparam int PTG_CTL_GP1_DATA = 1;
   localparam int PTG_CTL_GP0_OE   = 2;
   localparam int PTG_CTL_GP1_OE   = 3;
   localparam int PTG_CTL_GP4_DATA = 4;
   localparam int PTG_CTL_GP4_OE   = 5;
   localparam int PTG_CTL_GP3_OE   = 6;
   localparam int PTG_CTL_GP3_DATA = 7;

   // Pin state register fields
   localparam int PTG_ST_GP0  = 0;
   localparam int PTG_ST_GP1  = 1;
   localparam int PTG_ST_GP3  = 3;
   localparam int PTG_ST_GP4  = 4;
   localparam int PTG_ST_DIFF = 6;
   localparam int PTG_ST_TEST = 7;

   // Reset values: flash supply pin driven, supply off
   localparam logic [7:0] PTG_PIN_CTRL_RST = 8'h20;

   // Widths
   localparam int PTG_MISC_W  = 8;
   localparam int PTG_SBUS_W  = 27;
   localparam int PTG_TREE_W  = 13;
   localparam int PTG_SYNC_W  = 14;

endpackage

// >>> src/ptg_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_clk
// Notes:   Resets to all ones, the idle level of every pulled-up pin
`timescale 1ns/1ps
module ptg_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   // Data
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_reg <= '1;
         sync_reg <= '1;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule // ptg_sync

// >>> src/ptg_and_tree.sv
// Purpose: Balanced-free AND chain over the connectivity test pins
// Assumes: Inputs already synchronised
// Notes:   Any single low input pulls the result low
`timescale 1ns/1ps
module ptg_and_tree #(
   parameter int W = 2
) (
   // Pins under test
   input  wire logic [W-1:0] i_pins,
   // Tree output
   output logic              o_and
);

   logic [W-1:0] chain;

   assign chain[0] = i_pins[0];
   genvar g;
   generate
      for (g = 1; g < W; g++) begin : g_stage
         assign chain[g] = chain[g-1] & i_pins[g];
      end
   endgenerate

   assign o_and = chain[W-1];

endmodule // ptg_and_tree

// >>> src/ptg_pin_logic.sv
// Purpose: Connectivity test, general-purpose pins, EEPROM pairing, and
//          differential-sense float of the storage-bus outputs
// Assumes: Pin inputs asynchronous; core signals on i_clk
// Notes:   Every pin output and enable is registered
//
// Functional notes
// - Test select low: ordinary pins feed an AND tree onto result pin.
// - Storage-bus control and data lines stay out of the AND tree.
// - Entering test mode turns on pull-ups of participating pins.
// - Test mode floats all outputs except the enabled result pin.
// - Any participating pin driven low pulls the result output low.
// - Result pin carries test function only while select is low.
// - Fetch option on: pin 0 low flags next request is opcode fetch.
// - Pin 0 comes out of reset as an input.
// - Pin 0 EEPROM data driven from config 35h, readable at 07h.
// - Owner option on: pin 1 low while bus master; input after reset.
// - Pin 1 is EEPROM clock, pin 0 data, both via config 35h.
// - Pin 4 is an output after reset, flash supply enable.
// - Pin 3 comes out of reset as an input.
// - Differential mode with sense low floats all storage-bus outputs.
`timescale 1ns/1ps
module ptg_pin_logic (
   // Clock and reset
   input  wire logic                           i_clk,
   input  wire logic                           i_nrst,
   // Connectivity test
   input  wire logic                           i_test_mode_select_n,
   input  wire logic                           i_mem_access_ctl,
   input  wire logic                           i_mem_access_ctl_oe,
   output logic                                o_connectivity_result_out,
   output logic                                o_connectivity_result_oe,
   output logic                                o_pullup_en,
   // Options and core status
   input  wire logic                           i_fetch_ind_en,
   input  wire logic                           i_owner_ind_en,
   input  wire logic                           i_diff_xcvr_mode,
   input  wire logic                           i_next_is_fetch,
   input  wire logic                           i_is_bus_master,
   // General-purpose pins
   input  wire logic                           i_opcode_fetch_indicator_pin,
   output logic                                o_opcode_fetch_indicator_pin,
   output logic                                o_opcode_fetch_indicator_oe,
   input  wire logic                           i_bus_owner_indicator_pin,
   output logic                                o_bus_owner_indicator_pin,
   output logic                                o_bus_owner_indicator_oe,
   input  wire logic                           i_board_type_sense_pin,
   output logic                                o_board_type_sense_pin,
   output logic                                o_board_type_sense_oe,
   input  wire logic                           i_flash_supply_enable_pin,
   output logic                                o_flash_supply_enable_pin,
   output logic                                o_flash_supply_enable_oe,
   // Other ordinary pins
   input  wire logic [ptg_pkg::PTG_MISC_W-1:0] i_misc_pin_in,
   input  wire logic [ptg_pkg::PTG_MISC_W-1:0] i_misc_out,
   input  wire logic [ptg_pkg::PTG_MISC_W-1:0] i_misc_oe,
   output logic      [ptg_pkg::PTG_MISC_W-1:0] o_misc_pin_out,
   output logic      [ptg_pkg::PTG_MISC_W-1:0] o_misc_pin_oe,
   // Storage bus
   input  wire logic                           i_differential_sense_input,
   input  wire logic [ptg_pkg::PTG_SBUS_W-1:0] i_sbus_out,
   input  wire logic [ptg_pkg::PTG_SBUS_W-1:0] i_sbus_oe,
   output logic      [ptg_pkg::PTG_SBUS_W-1:0] o_sbus_pin_out,
   output logic      [ptg_pkg::PTG_SBUS_W-1:0] o_sbus_pin_oe,
   // Configuration space access
   input  wire logic                           i_cfg_wr,
   input  wire logic                           i_cfg_rd,
   input  wire logic [7:0]                     i_cfg_addr,
   input  wire logic [7:0]                     i_cfg_wdata,
   output logic      [7:0]                     o_cfg_rdata,
   // Operating register access
   input  wire logic                           i_op_rd,
   input  wire logic [7:0]                     i_op_addr,
   output logic      [7:0]                     o_op_rdata
);

   ////////////////////////////////////////////////////////////////////////
   // Decode helper

   function automatic logic ptg_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
      return addr == off;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [ptg_pkg::PTG_SYNC_W-1:0] pins_async;
   logic [ptg_pkg::PTG_SYNC_W-1:0] pins_sync;
   logic                           test_mode;
   logic                           diff_s;
   logic                           gp0_s;
   logic                           gp1_s;
   logic                           gp3_s;
   logic                           gp4_s;
   logic [ptg_pkg::PTG_MISC_W-1:0] misc_s;
   logic [ptg_pkg::PTG_TREE_W-1:0] tree_in;
   logic                           tree_and;

   assign pins_async = {i_test_mode_select_n, i_differential_sense_input,
                        i_flash_supply_enable_pin, i_board_type_sense_pin,
                        i_bus_owner_indicator_pin,
                        i_opcode_fetch_indicator_pin, i_misc_pin_in};

   ptg_sync #(.W(ptg_pkg::PTG_SYNC_W)) u_sync (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_async (pins_async),
      .o_sync  (pins_sync)
   );

   assign test_mode = ~pins_sync[13];
   assign diff_s    = pins_sync[12];
   assign gp4_s     = pins_sync[11];
   assign gp3_s     = pins_sync[10];
   assign gp1_s     = pins_sync[9];
   assign gp0_s     = pins_sync[8];
   assign misc_s    = pins_sync[7:0];

   ////////////////////////////////////////////////////////////////////////
   // AND tree; storage-bus lines deliberately absent

   assign tree_in = {diff_s, gp4_s, gp3_s, gp1_s, gp0_s, misc_s};

   ptg_and_tree #(.W(ptg_pkg::PTG_TREE_W)) u_tree (
      .i_pins (tree_in),
      .o_and  (tree_and)
   );

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic [7:0] cfg_rdata_reg;
   logic [7:0] cfg_rdata_next;
   logic [7:0] op_rdata_reg;
   logic [7:0] op_rdata_next;
   logic [7:0] pin_state;

   assign pin_state = {test_mode, diff_s, 1'b0, gp4_s, gp3_s, 1'b0,
                       gp1_s, gp0_s};

   always_comb begin
      ctl_next       = ctl_reg;
      cfg_rdata_next = cfg_rdata_reg;
      op_rdata_next  = op_rdata_reg;
      if (i_cfg_wr && ptg_hit(i_cfg_addr, ptg_pkg::PTG_PIN_CTRL_OFF)) begin
         ctl_next = i_cfg_wdata;
      end
      if (i_cfg_rd) begin
         cfg_rdata_next = ptg_hit(i_cfg_addr, ptg_pkg::PTG_PIN_CTRL_OFF) ?
                          ctl_reg : 8'h00;
      end
      if (i_op_rd) begin
         op_rdata_next = ptg_hit(i_op_addr, ptg_pkg::PTG_PIN_STATE_OFF) ?
                         pin_state : 8'h00;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctl_reg       <= ptg_pkg::PTG_PIN_CTRL_RST;
         cfg_rdata_reg <= 8'h00;
         op_rdata_reg  <= 8'h00;
      end else begin
         ctl_reg       <= ctl_next;
         cfg_rdata_reg <= cfg_rdata_next;
         op_rdata_reg  <= op_rdata_next;
      end
   end

   assign o_cfg_rdata = cfg_rdata_reg;
   assign o_op_rdata  = op_rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Pin drive

   logic                           res_out_reg, res_out_next;
   logic                           res_oe_reg, res_oe_next;
   logic                           pull_reg, pull_next;
   logic [3:0]                     gp_out_reg, gp_out_next;
   logic [3:0]                     gp_oe_reg, gp_oe_next;
   logic [ptg_pkg::PTG_MISC_W-1:0] misc_out_reg, misc_out_next;
   logic [ptg_pkg::PTG_MISC_W-1:0] misc_oe_reg, misc_oe_next;
   logic [ptg_pkg::PTG_SBUS_W-1:0] sb_out_reg, sb_out_next;
   logic [ptg_pkg::PTG_SBUS_W-1:0] sb_oe_reg, sb_oe_next;
   logic                           sb_float;

   // Floating protects the transceivers from a single-ended device
   assign sb_float = i_diff_xcvr_mode & ~diff_s;

   always_comb begin
      // Normal function first; test mode overrides below
      res_out_next  = i_mem_access_ctl;
      res_oe_next   = i_mem_access_ctl_oe;
      pull_next     = 1'b0;
      misc_out_next = i_misc_out;
      misc_oe_next  = i_misc_oe;
      sb_out_next   = i_sbus_out;
      sb_oe_next    = sb_float ? '0 : i_sbus_oe;
      // Index 0..3: pin 0, pin 1, pin 3, pin 4
      gp_out_next   = {ctl_reg[ptg_pkg::PTG_CTL_GP4_DATA],
                       ctl_reg[ptg_pkg::PTG_CTL_GP3_DATA],
                       ctl_reg[ptg_pkg::PTG_CTL_GP1_DATA],
                       ctl_reg[ptg_pkg::PTG_CTL_GP0_DATA]};
      gp_oe_next    = {ctl_reg[ptg_pkg::PTG_CTL_GP4_OE],
                       ctl_reg[ptg_pkg::PTG_CTL_GP3_OE],
                       ctl_reg[ptg_pkg::PTG_CTL_GP1_OE],
                       ctl_reg[ptg_pkg::PTG_CTL_GP0_OE]};
      if (i_fetch_ind_en) begin
         gp_out_next[0] = ~i_next_is_fetch;
         gp_oe_next[0]  = 1'b1;
      end
      if (i_owner_ind_en) begin
         gp_out_next[1] = ~i_is_bus_master;
         gp_oe_next[1]  = 1'b1;
      end
      if (test_mode) begin
         res_out_next = tree_and;
         res_oe_next  = 1'b1;
         pull_next    = 1'b1;
         misc_oe_next = '0;
         sb_oe_next   = '0;
         gp_oe_next   = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         res_out_reg  <= 1'b1;
         res_oe_reg   <= 1'b0;
         pull_reg     <= 1'b0;
         gp_out_reg   <= 4'h0;
         gp_oe_reg    <= 4'h8;
         misc_out_reg <= '0;
         misc_oe_reg  <= '0;
         sb_out_reg   <= '0;
         sb_oe_reg    <= '0;
      end else begin
         res_out_reg  <= res_out_next;
         res_oe_reg   <= res_oe_next;
         pull_reg     <= pull_next;
         gp_out_reg   <= gp_out_next;
         gp_oe_reg    <= gp_oe_next;
         misc_out_reg <= misc_out_next;
         misc_oe_reg  <= misc_oe_next;
         sb_out_reg   <= sb_out_next;
         sb_oe_reg    <= sb_oe_next;
      end
   end

   assign o_connectivity_result_out    = res_out_reg;
   assign o_connectivity_result_oe     = res_oe_reg;
   assign o_pullup_en                  = pull_reg;
   assign o_opcode_fetch_indicator_pin = gp_out_reg[0];
   assign o_opcode_fetch_indicator_oe  = gp_oe_reg[0];
   assign o_bus_owner_indicator_pin    = gp_out_reg[1];
   assign o_bus_owner_indicator_oe     = gp_oe_reg[1];
   assign o_board_type_sense_pin       = gp_out_reg[2];
   assign o_board_type_sense_oe        = gp_oe_reg[2];
   assign o_flash_supply_enable_pin    = gp_out_reg[3];
   assign o_flash_supply_enable_oe     = gp_oe_reg[3];
   assign o_misc_pin_out               = misc_out_reg;
   assign o_misc_pin_oe                = misc_oe_reg;
   assign o_sbus_pin_out               = sb_out_reg;
   assign o_sbus_pin_oe                = sb_oe_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   logic first_reg;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence fetch_req_s;
      !test_mode && i_fetch_ind_en && i_next_is_fetch;
   endsequence

   sequence owner_req_s;
      !test_mode && i_owner_ind_en && i_is_bus_master;
   endsequence

   sequence eep_drive_s;
      !test_mode && !i_fetch_ind_en && ctl_reg[ptg_pkg::PTG_CTL_GP0_OE];
   endsequence

   tree_result_a: assert property (test_mode |=>
      o_connectivity_result_out == $past(tree_and))
      else $error("result pin does not follow AND tree");
   tree_excl_a: assert property (tree_and == (&misc_s & gp0_s & gp1_s
      & gp3_s & gp4_s & diff_s))
      else $error("AND tree inputs wrong");
   pullup_on_a: assert property ($rose(test_mode) |=> o_pullup_en)
      else $error("pull-ups not enabled in test mode");
   test_float_a: assert property (test_mode |=>
      o_connectivity_result_oe && o_misc_pin_oe == '0 &&
      o_sbus_pin_oe == '0 && gp_oe_reg == 4'h0)
      else $error("outputs not floated in test mode");
   low_pin_a: assert property ((test_mode && !gp3_s) |=>
      !o_connectivity_result_out)
      else $error("low pin did not pull result low");
   normal_pin_a: assert property (!test_mode |=>
      o_connectivity_result_out == $past(i_mem_access_ctl) &&
      o_connectivity_result_oe == $past(i_mem_access_ctl_oe) && !o_pullup_en)
      else $error("result pin not in normal use");
   fetch_ind_a: assert property (fetch_req_s |=>
      o_opcode_fetch_indicator_oe && !o_opcode_fetch_indicator_pin)
      else $error("fetch indication missing");
   reset_dir_a: assert property (first_reg |->
      !o_opcode_fetch_indicator_oe && !o_bus_owner_indicator_oe &&
      !o_board_type_sense_oe && o_flash_supply_enable_oe)
      else $error("pin directions wrong after reset");
   eep_data_a: assert property (eep_drive_s |=>
      o_opcode_fetch_indicator_oe && o_opcode_fetch_indicator_pin ==
      $past(ctl_reg[ptg_pkg::PTG_CTL_GP0_DATA]))
      else $error("EEPROM data pin not driven from control");
   state_read_a: assert property ((i_op_rd && ptg_hit(i_op_addr,
      ptg_pkg::PTG_PIN_STATE_OFF)) |=>
      o_op_rdata[ptg_pkg::PTG_ST_GP0] == $past(gp0_s))
      else $error("pin state read wrong");
   owner_ind_a: assert property (owner_req_s |=>
      o_bus_owner_indicator_oe && !o_bus_owner_indicator_pin)
      else $error("bus owner indication missing");
   diff_float_a: assert property ((i_diff_xcvr_mode && !diff_s) |=>
      o_sbus_pin_oe == '0)
      else $error("storage bus not floated");
   release_a: assert property ($fell(test_mode) |=>
      !o_pullup_en && o_sbus_pin_oe == ($past(i_sbus_oe) &
      {ptg_pkg::PTG_SBUS_W{!$past(sb_float)}}))
      else $error("pins not restored after test");

endmodule // ptg_pin_logic

// >>> dv/ptg_board_model.sv
// Purpose: Board side of the general-purpose and misc pins
// Assumes: Every pin has a board pull-up; parts may only pull low
// Notes:   A released pin reads high, never its last driven value
`timescale 1ns/1ps
module ptg_board_model (
   // Device drive, gp order {pin4, pin3, pin1, pin0}
   input  wire logic [3:0] i_gp_out,
   input  wire logic [3:0] i_gp_oe,
   input  wire logic [7:0] i_misc_out,
   input  wire logic [7:0] i_misc_oe,
   // Board parts pulling a pin low
   input  wire logic [3:0] i_gp_pull_low,
   input  wire logic [7:0] i_misc_pull_low,
   // Resolved pin levels
   output logic      [3:0] o_gp_level,
   output logic      [7:0] o_misc_level
);
   // Low pull wins over device drive, like a shorted pin on the board
   assign o_gp_level   = (~i_gp_oe | i_gp_out) & ~i_gp_pull_low;
   assign o_misc_level = (~i_misc_oe | i_misc_out) & ~i_misc_pull_low;
endmodule // ptg_board_model

// >>> dv/pin_test_and_gpio_logic_tb_top.sv
// Purpose: Self-checking bench for the pin test and gp pin logic
// Assumes: Inputs driven at falling edge; one 125 MHz clock
// Notes:   Waits of 4 cover the 2-flop sync plus output register
`timescale 1ns/1ps
module pin_test_and_gpio_logic_tb_top;
   logic        i_clk, i_nrst, i_test_mode_select_n;
   logic        i_mem_access_ctl, i_mem_access_ctl_oe;
   logic        o_connectivity_result_out, o_connectivity_result_oe;
   logic        o_pullup_en, i_fetch_ind_en, i_owner_ind_en;
   logic        i_diff_xcvr_mode, i_next_is_fetch, i_is_bus_master;
   logic        i_opcode_fetch_indicator_pin, o_opcode_fetch_indicator_pin;
   logic        o_opcode_fetch_indicator_oe, i_bus_owner_indicator_pin;
   logic        o_bus_owner_indicator_pin, o_bus_owner_indicator_oe;
   logic        i_board_type_sense_pin, o_board_type_sense_pin;
   logic        o_board_type_sense_oe, i_flash_supply_enable_pin;
   logic        o_flash_supply_enable_pin, o_flash_supply_enable_oe;
   logic [7:0]  i_misc_pin_in, i_misc_out, i_misc_oe;
   logic [7:0]  o_misc_pin_out, o_misc_pin_oe;
   logic        i_differential_sense_input;
   logic [26:0] i_sbus_out, i_sbus_oe, o_sbus_pin_out, o_sbus_pin_oe;
   logic        i_cfg_wr, i_cfg_rd, i_op_rd;
   logic [7:0]  i_cfg_addr, i_cfg_wdata, o_cfg_rdata, i_op_addr;
   logic [7:0]  o_op_rdata, misc_pull_low, rd;
   logic [3:0]  gp_pull_low, gp_level;
   int          n_fail, check_count;
   logic [1:0]  res_io, gp0_io, gp1_io;

   ////////////////////////////////////////////////////////////////////////
   ptg_pin_logic DUT (
      .i_clk, .i_nrst, .i_test_mode_select_n, .i_mem_access_ctl,
      .i_mem_access_ctl_oe, .o_connectivity_result_out,
      .o_connectivity_result_oe, .o_pullup_en, .i_fetch_ind_en,
      .i_owner_ind_en, .i_diff_xcvr_mode, .i_next_is_fetch, .i_is_bus_master,
      .i_opcode_fetch_indicator_pin, .o_opcode_fetch_indicator_pin,
      .o_opcode_fetch_indicator_oe, .i_bus_owner_indicator_pin,
      .o_bus_owner_indicator_pin, .o_bus_owner_indicator_oe,
      .i_board_type_sense_pin, .o_board_type_sense_pin,
      .o_board_type_sense_oe, .i_flash_supply_enable_pin,
      .o_flash_supply_enable_pin, .o_flash_supply_enable_oe,
      .i_misc_pin_in, .i_misc_out, .i_misc_oe, .o_misc_pin_out,
      .o_misc_pin_oe, .i_differential_sense_input, .i_sbus_out, .i_sbus_oe,
      .o_sbus_pin_out, .o_sbus_pin_oe, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
      .i_cfg_wdata, .o_cfg_rdata, .i_op_rd, .i_op_addr, .o_op_rdata);

   ptg_board_model board (
      .i_gp_out({o_flash_supply_enable_pin, o_board_type_sense_pin,
                 o_bus_owner_indicator_pin, o_opcode_fetch_indicator_pin}),
      .i_gp_oe({o_flash_supply_enable_oe, o_board_type_sense_oe,
                o_bus_owner_indicator_oe, o_opcode_fetch_indicator_oe}),
      .i_misc_out(o_misc_pin_out), .i_misc_oe(o_misc_pin_oe),
      .i_gp_pull_low(gp_pull_low), .i_misc_pull_low(misc_pull_low),
      .o_gp_level(gp_level), .o_misc_level(i_misc_pin_in));
   assign {i_flash_supply_enable_pin, i_board_type_sense_pin,
           i_bus_owner_indicator_pin, i_opcode_fetch_indicator_pin} = gp_level;
   assign res_io = {o_connectivity_result_oe, o_connectivity_result_out};
   assign gp0_io = {o_opcode_fetch_indicator_oe, o_opcode_fetch_indicator_pin};
   assign gp1_io = {o_bus_owner_indicator_oe, o_bus_owner_indicator_pin};

   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      i_cfg_wr = 1'b1;
      i_cfg_addr = a;
      i_cfg_wdata = d;
      tick(1);
      i_cfg_wr = 1'b0;
   endtask

   task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
      i_cfg_rd = 1'b1;
      i_cfg_addr = a;
      tick(1);
      i_cfg_rd = 1'b0;
      d = o_cfg_rdata;
   endtask

   task automatic op_rd(input logic [7:0] a, output logic [7:0] d);
      i_op_rd = 1'b1;
      i_op_addr = a;
      tick(1);
      i_op_rd = 1'b0;
      d = o_op_rdata;
   endtask

   task automatic results();
      $display("checks %0d, failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      check(o_opcode_fetch_indicator_oe, 1'b0);
      check(o_bus_owner_indicator_oe, 1'b0);
      check(o_board_type_sense_oe, 1'b0);
      check(o_flash_supply_enable_oe, 1'b1);
      cfg_rd(8'h35, rd);
      check(rd, 8'h20);
   endtask

   task automatic test_eeprom();
      cfg_wr(8'h35, 8'h2D);
      gp_pull_low = 4'h4;
      tick(4);
      check(gp0_io, 2'h3);
      check(gp1_io, 2'h2);
      op_rd(8'h07, rd);
      check(rd & 8'h1B, 8'h01);
      cfg_wr(8'h35, 8'h2E);
      tick(2);
      check({gp0_io[0], gp1_io[0]}, 2'h1);
      cfg_wr(8'h34, 8'h00);
      cfg_rd(8'h35, rd);
      check(rd, 8'h2E);
      // Pins 3 and 4 both driven high from the control register
      cfg_wr(8'h35, 8'hF0);
      tick(2);
      check(o_flash_supply_enable_pin, 1'b1);
      check(o_board_type_sense_pin, 1'b1);
      op_rd(8'h10, rd);
      check(rd, 8'h00);
      gp_pull_low = 4'h0;
      cfg_wr(8'h35, 8'h20);
   endtask

   task automatic test_indicators();
      i_fetch_ind_en = 1'b1;
      i_owner_ind_en = 1'b1;
      i_next_is_fetch = 1'b1;
      i_is_bus_master = 1'b0;
      tick(2);
      check(gp0_io, 2'h2);
      check(gp1_io, 2'h3);
      i_next_is_fetch = 1'b0;
      i_is_bus_master = 1'b1;
      tick(2);
      check(gp0_io, 2'h3);
      check(gp1_io, 2'h2);
      i_fetch_ind_en = 1'b0;
      i_owner_ind_en = 1'b0;
   endtask

   task automatic test_diff();
      i_sbus_oe = '1;
      i_sbus_out = 27'h2A5A5A5;
      i_diff_xcvr_mode = 1'b1;
      i_differential_sense_input = 1'b0;
      tick(4);
      check(o_sbus_pin_oe, 27'h0);
      i_differential_sense_input = 1'b1;
      tick(4);
      check(o_sbus_pin_oe, 27'h7FFFFFF);
      check(o_sbus_pin_out, 27'h2A5A5A5);
      i_diff_xcvr_mode = 1'b0;
      i_differential_sense_input = 1'b0;
      tick(4);
      check(o_sbus_pin_oe, 27'h7FFFFFF);
      i_differential_sense_input = 1'b1;
   endtask

   // Each pin is pulled low alone, so a missing tree input shows up
   task automatic test_and_tree();
      i_misc_oe = 8'hFF;
      i_misc_out = 8'hA5;
      i_mem_access_ctl_oe = 1'b1;
      tick(2);
      check(res_io, 2'h2);
      check(o_misc_pin_out, 8'hA5);
      i_test_mode_select_n = 1'b0;
      // Pins let go by the float need one more sync pass into the tree
      tick(8);
      check(res_io, 2'h3);
      check(o_pullup_en, 1'b1);
      check({o_opcode_fetch_indicator_oe, o_bus_owner_indicator_oe,
             o_board_type_sense_oe, o_flash_supply_enable_oe}, 4'h0);
      check({o_misc_pin_oe, o_sbus_pin_oe}, 35'h0);
      for (int k = 0; k < 12; k++) begin
         if (k < 8) misc_pull_low = 8'h01 << k;
         else gp_pull_low = 4'h1 << (k - 8);
         tick(4);
         check(o_connectivity_result_out, 1'b0);
         misc_pull_low = 8'h00;
         gp_pull_low = 4'h0;
         tick(4);
         check(o_connectivity_result_out, 1'b1);
      end
      i_differential_sense_input = 1'b0;
      tick(4);
      check(o_connectivity_result_out, 1'b0);
      op_rd(8'h07, rd);
      check(rd, 8'h9B);
      i_differential_sense_input = 1'b1;
      i_sbus_out = 27'h0;
      i_sbus_oe = 27'h0;
      tick(4);
      check(o_connectivity_result_out, 1'b1);
      i_test_mode_select_n = 1'b1;
      tick(4);
      check(res_io, 2'h2);
      check({o_pullup_en, o_flash_supply_enable_oe, o_misc_pin_oe},
            10'h1FF);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {i_nrst, i_mem_access_ctl, i_mem_access_ctl_oe} = 3'h0;
      {i_fetch_ind_en, i_owner_ind_en, i_diff_xcvr_mode} = 3'h0;
      {i_next_is_fetch, i_is_bus_master, i_cfg_wr, i_cfg_rd, i_op_rd} = 5'h0;
      i_test_mode_select_n = 1'b1;
      i_differential_sense_input = 1'b1;
      {i_misc_out, i_misc_oe, misc_pull_low} = 24'h0;
      {i_sbus_out, i_sbus_oe} = 54'h0;
      {i_cfg_addr, i_cfg_wdata, i_op_addr} = 24'h0;
      gp_pull_low = 4'h0;
      n_fail = 0;
      check_count = 0;
      repeat (4) @(negedge i_clk);
      i_nrst = 1'b1;
      tick(1);
      test_reset();
      test_eeprom();
      test_indicators();
      test_diff();
      test_and_tree();
      results();
   end

   // About 160 cycles of tests; this leaves a wide margin
   initial begin
      #100000;
      n_fail++;
      results();
   end
endmodule // pin_test_and_gpio_logic_tb_top
